// ===== design/usbef_pkg.sv
package usbef_pkg;

    // Bus map.
    localparam int          APB_ADDR_W   = 12;
    localparam logic [11:0] ADDR_IRQ_EN  = 12'h000;
    localparam logic [11:0] ADDR_STATUS  = 12'h004;
    localparam logic [11:0] ADDR_CLEAR   = 12'h008;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] IRQ_EN_RESET = 32'h0000_0000;

    // Status bit positions.
    localparam int BIT_LINE_RESET       = 31;
    localparam int BIT_LINE_SUSPEND     = 30;
    localparam int BIT_LINE_RESUME      = 29;
    localparam int BIT_SOF              = 26;
    localparam int BIT_CTRL_TOKEN_SEEN  = 24;
    localparam int BIT_CTRL_SETUP_DONE  = 23;
    localparam int BIT_CTRL_IN_ACKED    = 22;
    localparam int BIT_CTRL_OUT_ACKED   = 21;
    localparam int BIT_CTRL_IN_STALLED  = 20;
    localparam int BIT_CTRL_OUT_STALLED = 19;
    localparam int BIT_SETUP_BAD        = 18;
    localparam int BIT_HOST_TIMEOUT     = 17;
    localparam int BIT_DATA_ACKED_LO    = 8;
    localparam int BIT_DATA_REFUSED_LO  = 0;
    localparam int DATA_EPS             = 4;

    // Field masks of the status and enable words.
    localparam logic [31:0] STATUS_MASK    = 32'hE5FE_0F0F;
    localparam logic [31:0] CLEAR_MASK     = 32'hA5FE_0F0F;
    localparam logic [31:0] LINE_IRQ_MASK  = 32'hE000_0000;
    localparam logic [31:0] XFER_IRQ_MASK  = 32'h00F8_0F00;
    localparam logic [31:0] QUIET_MASK     = 32'h0106_0000;
    localparam logic [31:0] IRQ_EN_MASK    = 32'hE000_001F;

    // Interrupt enable bit positions.
    localparam int IE_LINE     = 31;
    localparam int IE_SOF      = 30;
    localparam int IE_XFER     = 29;
    localparam int IE_DATA_ACK = 4;
    localparam int IE_NAK_LO   = 0;

    // Timing.
    localparam int CLK_NS         = 50;
    localparam int SE0_MIN_NS     = 2500;
    localparam int IDLE_MIN_MS    = 3;
    localparam int RESP_MAX_NS    = 1400;
    localparam int SE0_CNT_W      = 7;
    localparam int LINE_CNT_W     = 20;
    localparam int RESP_CNT_W     = 6;
    localparam logic [SE0_CNT_W-1:0] SE0_CYC =
        SE0_CNT_W'((SE0_MIN_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [LINE_CNT_W-1:0] IDLE_CYC_DEF =
        LINE_CNT_W'(IDLE_MIN_MS * 1000000 / CLK_NS);
    localparam logic [RESP_CNT_W-1:0] RESP_CYC =
        RESP_CNT_W'(RESP_MAX_NS / CLK_NS);
    localparam logic [6:0] SETUP_BYTES = 7'h08;

    typedef enum logic {MON_ACTIVE, MON_SUSPENDED} usbef_mon_e;

endpackage

// ===== design/usbef_line_mon.sv
`timescale 1ns/1ns
module usbef_line_mon
    import usbef_pkg::*;
#(
    parameter logic [LINE_CNT_W-1:0] IDLE_CYC = IDLE_CYC_DEF
) (
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    // Line pins.
    input  wire logic usb_dp,
    input  wire logic usb_dm,
    // Line events.
    output logic      line_reset_evt,
    output logic      line_suspend_evt,
    output logic      line_resume_evt,
    output logic      line_wake
);

    logic                  dp_meta, dp_sync, dm_meta, dm_sync;
    logic [SE0_CNT_W-1:0]  se0_cnt;
    logic [LINE_CNT_W-1:0] idle_cnt;
    usbef_mon_e            mon;
    logic                  se0, idle, kst;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dp_meta <= 1'b0;
            dp_sync <= 1'b0;
            dm_meta <= 1'b0;
            dm_sync <= 1'b0;
        end else begin
            dp_meta <= usb_dp;
            dp_sync <= dp_meta;
            dm_meta <= usb_dm;
            dm_sync <= dm_meta;
        end
    end

    assign se0  = !dp_sync && !dm_sync;
    assign idle = dp_sync && !dm_sync;
    assign kst  = !dp_sync && dm_sync;

    // The counter saturates one past the limit so one SE0 gives one event.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            se0_cnt        <= '0;
            line_reset_evt <= 1'b0;
        end else begin
            line_reset_evt <= se0 && se0_cnt == SE0_CYC;
            if (!se0)
                se0_cnt <= '0;
            else if (se0_cnt <= SE0_CYC)
                se0_cnt <= se0_cnt + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon              <= MON_ACTIVE;
            idle_cnt         <= '0;
            line_suspend_evt <= 1'b0;
            line_resume_evt  <= 1'b0;
            line_wake        <= 1'b0;
        end else begin
            line_suspend_evt <= 1'b0;
            line_resume_evt  <= 1'b0;
            line_wake        <= 1'b0;
            case (mon)
                MON_ACTIVE: begin
                    if (!idle) begin
                        idle_cnt <= '0;
                    end else if (idle_cnt == IDLE_CYC) begin
                        mon              <= MON_SUSPENDED;
                        line_suspend_evt <= 1'b1;
                        idle_cnt         <= '0;
                    end else begin
                        idle_cnt <= idle_cnt + 1'b1;
                    end
                end
                MON_SUSPENDED: begin
                    if (!idle) begin
                        mon             <= MON_ACTIVE;
                        line_wake       <= 1'b1;
                        line_resume_evt <= kst;
                    end
                end
                default: mon <= MON_ACTIVE;
            endcase
        end
    end

    a_reset_length: assert property (
        @(posedge pclk) disable iff (!presetn)
        line_reset_evt |-> se0_cnt == SE0_CYC + 1'b1 && $past(se0, 2))
        else $error("reset flag without full SE0 length");

endmodule

// ===== design/usbef_xact_chk.sv
`timescale 1ns/1ns
module usbef_xact_chk
    import usbef_pkg::*;
(
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Setup payload report.
    input  wire logic       setup_data_end,
    input  wire logic [6:0] setup_byte_cnt,
    input  wire logic       setup_pid_data0,
    // IN handshake tracking.
    input  wire logic       in_data_sent,
    input  wire logic       host_ack_rx,
    // Error events.
    output logic            setup_bad_evt,
    output logic            host_timeout_evt
);

    logic                  armed;
    logic [RESP_CNT_W-1:0] resp_cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            setup_bad_evt <= 1'b0;
        else
            setup_bad_evt <= setup_data_end &&
                (setup_byte_cnt != SETUP_BYTES || !setup_pid_data0);
    end

    // A new IN packet restarts the wait; an ACK in the last cycle still counts.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed            <= 1'b0;
            resp_cnt         <= '0;
            host_timeout_evt <= 1'b0;
        end else begin
            host_timeout_evt <= 1'b0;
            if (in_data_sent) begin
                armed    <= 1'b1;
                resp_cnt <= '0;
            end else if (armed) begin
                if (host_ack_rx) begin
                    armed <= 1'b0;
                end else if (resp_cnt == RESP_CYC - 1'b1) begin
                    armed            <= 1'b0;
                    host_timeout_evt <= 1'b1;
                end else begin
                    resp_cnt <= resp_cnt + 1'b1;
                end
            end
        end
    end

    a_setup_good: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup_data_end && setup_byte_cnt == SETUP_BYTES && setup_pid_data0
        |=> !setup_bad_evt)
        else $error("good setup payload flagged as bad");

    a_timeout_delay: assert property (
        @(posedge pclk) disable iff (!presetn)
        host_timeout_evt |-> $past(in_data_sent, 29))
        else $error("timeout not at the response limit");

endmodule

// ===== design/usbef_event_flags.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// How it works
// - Flag bus reset after long SE0.
// - Flag suspend after long idle line.
// - Flag resume seen while suspended.
// - Flag every received start of frame.
// - Flag control setup token, never interrupting.
// - Flag completed control setup transaction.
// - Flag control IN acknowledged by host.
// - Flag control OUT acknowledged.
// - Flag control IN ended with stall.
// - Flag control OUT ended with stall.
// - Flag malformed setup payload, no interrupt.
// - Flag missing host ACK, no interrupt.
// - Per data endpoint ACK completion flags.
// - Per data endpoint NAK flags.
// - Status word read only, zero after reset.
// - Line enable passes reset, suspend, resume.
// - Transfer enable passes control setup done, ACK and stall flags and data endpoint ACKs, not NAKs.
// - Clear bits written zero change nothing.
//////////////////////////////////////////////////////////////////////////////
module usbef_event_flags
    import usbef_pkg::*;
#(
    parameter logic [LINE_CNT_W-1:0] IDLE_CYC = IDLE_CYC_DEF
) (
    // Clock and reset.
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave.
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [APB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Line pins.
    input  wire logic                  usb_dp,
    input  wire logic                  usb_dm,
    // Transaction events from the serial engine.
    input  wire logic                  sof_rx,
    input  wire logic                  ctrl_token_seen,
    input  wire logic                  ctrl_setup_done,
    input  wire logic                  ctrl_in_acked,
    input  wire logic                  ctrl_out_acked,
    input  wire logic                  ctrl_in_stalled,
    input  wire logic                  ctrl_out_stalled,
    input  wire logic [DATA_EPS-1:0]   data_ep_acked,
    input  wire logic [DATA_EPS-1:0]   data_ep_refused,
    // Setup payload and IN handshake reports.
    input  wire logic                  setup_data_end,
    input  wire logic [6:0]            setup_byte_cnt,
    input  wire logic                  setup_pid_data0,
    input  wire logic                  in_data_sent,
    input  wire logic                  host_ack_rx,
    // Interrupt.
    output logic                       usb_irq
);

    //////////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic logic flag_next(input logic cur, input logic set,
                                       input logic clr);
        flag_next = set || (cur && !clr);
    endfunction

    function automatic logic [31:0] lane_bits(input logic [3:0] strb);
        lane_bits = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    function automatic logic reg_hit(input logic [APB_ADDR_W-1:0] addr,
                                     input logic [APB_ADDR_W-1:0] offs);
        reg_hit = addr == offs;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Event sources.

    logic line_reset_evt, line_suspend_evt, line_resume_evt, line_wake;
    logic setup_bad_evt, host_timeout_evt;

    usbef_line_mon #(
        .IDLE_CYC         (IDLE_CYC)
    ) u_line_mon (
        .pclk             (pclk),
        .presetn          (presetn),
        .usb_dp           (usb_dp),
        .usb_dm           (usb_dm),
        .line_reset_evt   (line_reset_evt),
        .line_suspend_evt (line_suspend_evt),
        .line_resume_evt  (line_resume_evt),
        .line_wake        (line_wake)
    );

    usbef_xact_chk u_xact_chk (
        .pclk             (pclk),
        .presetn          (presetn),
        .setup_data_end   (setup_data_end),
        .setup_byte_cnt   (setup_byte_cnt),
        .setup_pid_data0  (setup_pid_data0),
        .in_data_sent     (in_data_sent),
        .host_ack_rx      (host_ack_rx),
        .setup_bad_evt    (setup_bad_evt),
        .host_timeout_evt (host_timeout_evt)
    );

    //////////////////////////////////////////////////////////////////////////
    // Bus decode.

    logic        access, wr_irq_en, wr_status, wr_clear, mapped;
    logic [31:0] fw_clear;

    assign access    = psel && penable;
    assign mapped    = reg_hit(paddr, ADDR_IRQ_EN) ||
                       reg_hit(paddr, ADDR_STATUS) ||
                       reg_hit(paddr, ADDR_CLEAR);
    assign wr_irq_en = access && pwrite && reg_hit(paddr, ADDR_IRQ_EN);
    assign wr_status = access && pwrite && reg_hit(paddr, ADDR_STATUS);
    assign wr_clear  = access && pwrite && reg_hit(paddr, ADDR_CLEAR);
    assign pready    = 1'b1;
    assign pslverr   = access && !mapped;

    // Only ones in strobed lanes clear; zeros leave their flags alone.
    assign fw_clear = wr_clear ? (pwdata & lane_bits(pstrb) & CLEAR_MASK)
                               : 32'h0000_0000;

    //////////////////////////////////////////////////////////////////////////
    // Event flags.

    logic [31:0] event_status_reg;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;

    always_comb begin
        set_vec                       = 32'h0000_0000;
        set_vec[BIT_LINE_RESET]       = line_reset_evt;
        set_vec[BIT_LINE_SUSPEND]     = line_suspend_evt;
        set_vec[BIT_LINE_RESUME]      = line_resume_evt;
        set_vec[BIT_SOF]              = sof_rx;
        set_vec[BIT_CTRL_TOKEN_SEEN]  = ctrl_token_seen;
        set_vec[BIT_CTRL_SETUP_DONE]  = ctrl_setup_done;
        set_vec[BIT_CTRL_IN_ACKED]    = ctrl_in_acked;
        set_vec[BIT_CTRL_OUT_ACKED]   = ctrl_out_acked;
        set_vec[BIT_CTRL_IN_STALLED]  = ctrl_in_stalled;
        set_vec[BIT_CTRL_OUT_STALLED] = ctrl_out_stalled;
        set_vec[BIT_SETUP_BAD]        = setup_bad_evt;
        set_vec[BIT_HOST_TIMEOUT]     = host_timeout_evt;
        set_vec[BIT_DATA_ACKED_LO +: DATA_EPS]   = data_ep_acked;
        set_vec[BIT_DATA_REFUSED_LO +: DATA_EPS] = data_ep_refused;
    end

    // The suspend flag has no firmware clear; it drops when the line wakes.
    always_comb begin
        clr_vec                   = fw_clear;
        clr_vec[BIT_LINE_SUSPEND] = line_wake;
    end

    // Status writes reach no flag; only events and the clear word do.
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_flag
            if (STATUS_MASK[gi]) begin : g_live
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn)
                        event_status_reg[gi] <= STATUS_RESET[gi];
                    else
                        event_status_reg[gi] <= flag_next(
                            event_status_reg[gi], set_vec[gi],
                            clr_vec[gi]);
                end
            end else begin : g_rsvd
                assign event_status_reg[gi] = 1'b0;
            end
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // Interrupt enable and request.

    logic [31:0] irq_en;
    logic        line_hit, sof_hit, xfer_hit, ack_hit, nak_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_en <= IRQ_EN_RESET;
        else if (wr_irq_en)
            irq_en <= ((irq_en & ~lane_bits(pstrb)) |
                       (pwdata & lane_bits(pstrb))) & IRQ_EN_MASK;
    end

    assign line_hit = irq_en[IE_LINE] &&
                      |(event_status_reg & LINE_IRQ_MASK);
    assign sof_hit  = irq_en[IE_SOF] && event_status_reg[BIT_SOF];
    assign xfer_hit = irq_en[IE_XFER] &&
                      |(event_status_reg & XFER_IRQ_MASK);
    assign ack_hit  = irq_en[IE_DATA_ACK] &&
                      |event_status_reg[BIT_DATA_ACKED_LO +: DATA_EPS];
    assign nak_hit  = |(event_status_reg[BIT_DATA_REFUSED_LO +: DATA_EPS] &
                        irq_en[IE_NAK_LO +: DATA_EPS]);

    // Registered so the interrupt line never glitches on flag updates.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            usb_irq <= 1'b0;
        else
            usb_irq <= line_hit || sof_hit || xfer_hit || ack_hit || nak_hit;
    end

    //////////////////////////////////////////////////////////////////////////
    // Read data.

    // Loaded in the setup cycle, so a flag set during the access phase
    // shows on the next read rather than tearing this one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (reg_hit(paddr, ADDR_IRQ_EN))
                prdata <= irq_en;
            else if (reg_hit(paddr, ADDR_STATUS))
                prdata <= event_status_reg;
            else
                prdata <= 32'h0000_0000;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks.

    a_reset_zero: assert property (
        @(posedge pclk) $rose(presetn) |-> event_status_reg == STATUS_RESET)
        else $error("status not zero after reset");

    a_rsvd_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        (event_status_reg & ~STATUS_MASK) == 32'h0000_0000)
        else $error("reserved status bit set");

    a_status_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_status && set_vec == 32'h0000_0000 && !line_wake
        |=> $stable(event_status_reg))
        else $error("status write changed a flag");

    a_reset_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        line_reset_evt ##1 !(wr_clear && pwdata[BIT_LINE_RESET])
        |-> event_status_reg[BIT_LINE_RESET])
        else $error("bus reset flag not held");

    a_suspend_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        line_suspend_evt |=> event_status_reg[BIT_LINE_SUSPEND])
        else $error("suspend flag not set");

    a_resume_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        line_resume_evt |=> event_status_reg[BIT_LINE_RESUME] &&
                            !event_status_reg[BIT_LINE_SUSPEND])
        else $error("resume flag not set");

    a_sof_set_wins: assert property (
        @(posedge pclk) disable iff (!presetn)
        sof_rx && wr_clear |=> event_status_reg[BIT_SOF])
        else $error("frame event lost to clear");

    a_ctrl_flags: assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_setup_done || ctrl_in_acked || ctrl_out_acked
        |=> |(event_status_reg & 32'h00E0_0000))
        else $error("control transaction flag missing");

    a_stall_flags: assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_in_stalled || ctrl_out_stalled
        |=> (!$past(ctrl_in_stalled) ||
             event_status_reg[BIT_CTRL_IN_STALLED]) &&
            (!$past(ctrl_out_stalled) ||
             event_status_reg[BIT_CTRL_OUT_STALLED]))
        else $error("stall flags missing");

    a_data_acked: assert property (
        @(posedge pclk) disable iff (!presetn)
        data_ep_acked[2] |=> event_status_reg[BIT_DATA_ACKED_LO + 2])
        else $error("endpoint ACK flag missing");

    a_data_refused: assert property (
        @(posedge pclk) disable iff (!presetn)
        data_ep_refused[3] |=> event_status_reg[BIT_DATA_REFUSED_LO + 3])
        else $error("endpoint NAK flag missing");

    a_clear_one: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_clear && pstrb[3] && pwdata[BIT_CTRL_TOKEN_SEEN] &&
        !ctrl_token_seen |=> !event_status_reg[BIT_CTRL_TOKEN_SEEN])
        else $error("clear did not drop flag");

    a_clear_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_clear && !pwdata[BIT_CTRL_IN_ACKED] &&
        event_status_reg[BIT_CTRL_IN_ACKED]
        |=> event_status_reg[BIT_CTRL_IN_ACKED])
        else $error("zero bit cleared a flag");

    a_quiet_flags: assert property (
        @(posedge pclk) disable iff (!presetn)
        (event_status_reg & ~QUIET_MASK) == 32'h0000_0000 |=> !usb_irq)
        else $error("quiet flag raised interrupt");

    a_line_irq: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq_en[IE_LINE] && event_status_reg[BIT_LINE_RESUME] |=> usb_irq)
        else $error("line event did not interrupt");

    a_nak_gated: assert property (
        @(posedge pclk) disable iff (!presetn)
        (event_status_reg & ~32'h0000_000F) == 32'h0000_0000 &&
        irq_en[IE_NAK_LO +: DATA_EPS] == 4'h0 |=> !usb_irq)
        else $error("NAK flag interrupted without its enable");

endmodule

// ===== sim/usbef_host_model.sv
`timescale 1ns/1ns
module usbef_host_model (
    // Clock and command from the bench.
    input  wire logic       pclk,
    input  wire logic [1:0] line_cmd,
    // Line pins.
    output logic            usb_dp,
    output logic            usb_dm
);
    // Traffic toggles J and K every cycle so the idle timer never reaches its limit.
    always_ff @(posedge pclk) begin
        case (line_cmd)
            2'h0:    {usb_dp, usb_dm} <= 2'h2;
            2'h1:    {usb_dp, usb_dm} <= 2'h0;
            2'h2:    {usb_dp, usb_dm} <= 2'h1;
            default: {usb_dp, usb_dm} <= (usb_dp === 1'b1) ? 2'h1 : 2'h2;
        endcase
    end
endmodule

// ===== sim/tb_usb_device_event_flags.sv
`timescale 1ns/1ns
module tb_usb_device_event_flags;
    import usbef_pkg::*;
    localparam int EB [15] = '{26,24,23,22,21,20,19,8,9,10,11,0,1,2,3};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        err, usb_dp, usb_dm, usb_irq, pid0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [17:0] ev;
    logic [6:0]  cnt;
    logic [1:0]  line_cmd;
    int          fails, total_checks;
    usbef_host_model host (.pclk(pclk), .line_cmd(line_cmd),
        .usb_dp(usb_dp), .usb_dm(usb_dm));
    usbef_event_flags #(.IDLE_CYC(40)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .usb_dp(usb_dp), .usb_dm(usb_dm),
        .sof_rx(ev[0]), .ctrl_token_seen(ev[1]), .ctrl_setup_done(ev[2]),
        .ctrl_in_acked(ev[3]), .ctrl_out_acked(ev[4]),
        .ctrl_in_stalled(ev[5]), .ctrl_out_stalled(ev[6]),
        .data_ep_acked(ev[10:7]), .data_ep_refused(ev[14:11]),
        .setup_data_end(ev[15]), .setup_byte_cnt(cnt),
        .setup_pid_data0(pid0), .in_data_sent(ev[16]),
        .host_ack_rx(ev[17]), .usb_irq(usb_irq));
    always #25 pclk = ~pclk;
    task automatic chk(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            fails++;
        end
    endtask
    // Optional event e fires at the edge that completes the access.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input int e);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        if (e >= 0) ev[e] <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0; ev <= '0;
        // One idle cycle, so the next call never re-drives these in one step.
        @(posedge pclk);
    endtask
    task automatic pulse(input int e);
        ev[e] <= 1'b1;
        @(posedge pclk);
        ev <= '0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic stat(input logic [31:0] e);
        apb(1'b0, ADDR_STATUS, 32'h0, -1);
        chk("status", rd, e);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        tally_and_finish;
    end
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = '0; pwdata = '0; ev = '0; cnt = 7'h08; pid0 = 1; line_cmd = 3;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        stat(32'h0);
        apb(1'b0, 12'h0FC, 32'h0, -1);
        chk("unmapped error", {31'h0, err}, 32'h1);
        for (int i = 0; i < 15; i++) begin
            pulse(i);
            stat(32'h1 << EB[i]);
            apb(1'b1, ADDR_CLEAR, 32'h0, -1);
            apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF, -1);
            stat(32'h1 << EB[i]);
            apb(1'b1, ADDR_CLEAR, 32'h1 << EB[i], -1);
            stat(32'h0);
        end
        apb(1'b1, ADDR_CLEAR, 32'h0400_0000, 0);
        stat(32'h0400_0000);
        apb(1'b1, ADDR_CLEAR, 32'hFFFF_FFFF, -1);
        pulse(15);
        stat(32'h0);
        cnt <= 7'h07;
        pulse(15);
        stat(32'h0004_0000);
        apb(1'b1, ADDR_CLEAR, 32'h0004_0000, -1);
        cnt <= 7'h08; pid0 <= 1'b0;
        pulse(15);
        stat(32'h0004_0000);
        apb(1'b1, ADDR_CLEAR, 32'h0004_0000, -1);
        pulse(16);
        repeat (6) @(posedge pclk);
        pulse(17);
        repeat (30) @(posedge pclk);
        stat(32'h0);
        pulse(16);
        repeat (35) @(posedge pclk);
        stat(32'h0002_0000);
        apb(1'b1, ADDR_IRQ_EN, 32'h2000_0000, -1);
        apb(1'b1, ADDR_CLEAR, 32'hFFFF_FFFF, -1);
        pulse(1);
        pulse(11);
        chk("irq quiet", {31'h0, usb_irq}, 32'h0);
        apb(1'b1, ADDR_IRQ_EN, 32'h2000_0001, -1);
        @(posedge pclk);
        chk("irq nak", {31'h0, usb_irq}, 32'h1);
        apb(1'b1, ADDR_IRQ_EN, 32'h2000_0000, -1);
        pulse(2);
        chk("irq xfer", {31'h0, usb_irq}, 32'h1);
        apb(1'b1, ADDR_CLEAR, 32'hFFFF_FFFF, -1);
        apb(1'b1, ADDR_IRQ_EN, 32'h8000_0000, -1);
        line_cmd <= 2'h1;
        repeat (60) @(posedge pclk);
        line_cmd <= 2'h3;
        stat(32'h8000_0000);
        chk("irq line", {31'h0, usb_irq}, 32'h1);
        apb(1'b1, ADDR_CLEAR, 32'h8000_0000, -1);
        line_cmd <= 2'h0;
        repeat (50) @(posedge pclk);
        stat(32'h4000_0000);
        line_cmd <= 2'h2;
        repeat (8) @(posedge pclk);
        line_cmd <= 2'h3;
        stat(32'h2000_0000);
        apb(1'b1, ADDR_CLEAR, 32'h2000_0000, -1);
        stat(32'h0);
        tally_and_finish;
    end
endmodule
